// File: design/gp78_ports.sv
// Ports 7 and 8: APB register file, pin sharing and standby pin float.
// Assumes an APB master on CLK_SYS, pins synchronous to CLK_SYS, and an
// outside standby controller that raises STANDBY_MODE in stop/watch mode.
//
// Notes on behaviour
// R01 - Direction bit one makes pin output
// R02 - Output pin drives its latch bit
// R03 - Latch write appears directly on outputs
// R04 - Output pin read returns latch value
// R05 - Direction bit zero makes pin input
// R06 - Input pin: latch written, not driven
// R07 - Input read gives pin; RMW gives latch
// R08 - Enabled peripheral output replaces latch drive
// R09 - Peripheral pin read gives level; RMW latch
// R10 - Pin level always readable through data; output pins read the latch instead
// R11 - Reset clears all direction bits
// R12 - Float bit in standby floats all pins
// R13 - Floated pins read low, inputs blocked
// R14 - Port 8 trigger pin kept if irq enabled
// R15 - Float bit zero: standby holds pin states
// R16 - Pull-up enable bit connects pull-up
// R17 - Driving low disconnects pull-up
// R18 - Port 7 uses bits 0 to 2
// R19 - Port 8 uses bits 0 to 3
// R20 - Trigger inputs routed from port 1 or 8
// R21 - Software disables peripheral output before port use
// R22 - Unimplemented bits ignore writes, read zero
//
// The APB slave port and the register addresses were decided locally.
`timescale 1ns/1ns
`include "gp78_defs.svh"
module gp78_ports
  import gp78_pkg::*;
#(
  parameter int P7_WIDTH = 3,
  parameter int P8_WIDTH = 4
) (
  input  wire logic                CLK_SYS,
  input  wire logic                SYS_RST,
  input  wire logic                PSEL,
  input  wire logic                PENABLE,
  input  wire logic                PWRITE,
  input  wire logic [7:0]          PADDR,
  input  wire logic [31:0]         PWDATA,
  input  wire logic [3:0]          PSTRB,
  output logic      [31:0]         PRDATA,
  output logic                     PREADY,
  output logic                     PSLVERR,
  input  wire logic                STANDBY_MODE,
  input  wire logic [P7_WIDTH-1:0] P7_IN,
  output logic      [P7_WIDTH-1:0] P7_OUT,
  output logic      [P7_WIDTH-1:0] P7_OE,
  output logic      [P7_WIDTH-1:0] P7_PULLUP,
  input  wire logic [P8_WIDTH-1:0] P8_IN,
  output logic      [P8_WIDTH-1:0] P8_OUT,
  output logic      [P8_WIDTH-1:0] P8_OE,
  output logic      [P8_WIDTH-1:0] P8_PULLUP,
  input  wire logic                TMR0_OUT,
  input  wire logic                TMR0_OUT_EN,
  output logic                     TMR0_IN,
  input  wire logic                P1_TRIG_IN,
  output logic                     PPG_TRIG,
  output logic                     ADC_TRIG
);

  // Shared pins need bit 1 of port 7 and bit 3 of port 8; one byte each
  if (P7_WIDTH < 2 || P7_WIDTH > 8) begin : g_p7_chk
    $error("P7_WIDTH must lie in 2..8");
  end
  if (P8_WIDTH < 4 || P8_WIDTH > 8) begin : g_p8_chk
    $error("P8_WIDTH must lie in 4..8");
  end

  // Address decode, shared by the write and read paths
  function automatic gp78_reg_t reg_decode(input logic [7:0] a);
    gp78_reg_t r;
    r = GP78_REG_NONE;
    if (a == `GP78_OFS_P7_DATA) begin
      r = GP78_P7_DATA;
    end else if (a == `GP78_OFS_P7_DIR) begin
      r = GP78_P7_DIR;
    end else if (a == `GP78_OFS_P7_PUL) begin
      r = GP78_P7_PUL;
    end else if (a == `GP78_OFS_P7_LATCH) begin
      r = GP78_P7_LATCH;
    end else if (a == `GP78_OFS_P8_DATA) begin
      r = GP78_P8_DATA;
    end else if (a == `GP78_OFS_P8_DIR) begin
      r = GP78_P8_DIR;
    end else if (a == `GP78_OFS_P8_PUL) begin
      r = GP78_P8_PUL;
    end else if (a == `GP78_OFS_P8_LATCH) begin
      r = GP78_P8_LATCH;
    end else if (a == `GP78_OFS_CFG) begin
      r = GP78_CFG;
    end
    return r;
  endfunction

  // Ordinary data read: latch for a port output, pin level otherwise
  function automatic logic [7:0] data_view(input logic [7:0] latch,
                                           input logic [7:0] dir,
                                           input logic [7:0] per_oe,
                                           input logic [7:0] lvl);
    logic [7:0] own;
    own = dir & ~per_oe;
    return (own & latch) | (~own & lvl);            // see R04 R07 R09 R10
  endfunction

  logic [P7_WIDTH-1:0]   p7_latch_q;
  logic [P7_WIDTH-1:0]   p7_dir_q;
  logic [P7_WIDTH-1:0]   p7_pul_q;
  logic [P8_WIDTH-1:0]   p8_latch_q;
  logic [P8_WIDTH-1:0]   p8_dir_q;
  logic [P8_WIDTH-1:0]   p8_pul_q;
  logic [`GP78_CFG_W-1:0] cfg_q;
  logic [P7_WIDTH-1:0]   p7_lvl;
  logic [P8_WIDTH-1:0]   p8_lvl;
  logic [P7_WIDTH-1:0]   p7_per_oe;
  logic [P7_WIDTH-1:0]   p7_per_out;
  logic [P8_WIDTH-1:0]   p8_keep;
  logic                  float_w;
  logic                  wr_en;
  logic                  setup;
  gp78_reg_t             sel;
  logic [31:0]           prdata_d;
  logic                  trig_d;

  // Bus phases; registers live in byte lane 0 only
  assign setup = PSEL & ~PENABLE;
  assign sel   = reg_decode(PADDR);
  assign wr_en = PSEL & PENABLE & PWRITE & PREADY & PSTRB[0];

  // Standby float is the config bit qualified by stop/watch mode
  assign float_w = cfg_q[`GP78_CFG_FLOAT] & STANDBY_MODE; // see R12 R15

  // Timer output shares port 7 bit 0; no peripheral output drives port 8 pins
  always_comb begin
    p7_per_oe                   = '0;
    p7_per_out                  = '0;
    p7_per_oe[`GP78_P7_TMR_OUT]  = TMR0_OUT_EN;       // see R08
    p7_per_out[`GP78_P7_TMR_OUT] = TMR0_OUT;
  end

  // Trigger pin stays live when both interrupt enables are set
  always_comb begin
    p8_keep              = '0;
    p8_keep[`GP78_P8_TRIG] = cfg_q[`GP78_CFG_IRQ_CH0] &
                           cfg_q[`GP78_CFG_IRQ_PSEL]; // see R14
  end

  // Answer one cycle after setup: zero wait states
  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      PREADY <= 1'b0;
    end else begin
      PREADY <= setup;
    end
  end

  // Unmapped addresses answer with an error, writes ignored
  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      PSLVERR <= 1'b0;
    end else if (setup) begin
      PSLVERR <= (sel == GP78_REG_NONE);
    end else begin
      PSLVERR <= 1'b0;
    end
  end

  // Read mux; bits above the port width read zero
  always_comb begin
    prdata_d = '0;
    case (sel)
      GP78_P7_DATA:  prdata_d[7:0] = data_view(8'(p7_latch_q),
                       8'(p7_dir_q), 8'(p7_per_oe), 8'(p7_lvl));
      GP78_P7_DIR:   prdata_d[7:0] = 8'(p7_dir_q);    // see R18 R22
      GP78_P7_PUL:   prdata_d[7:0] = 8'(p7_pul_q);
      GP78_P7_LATCH: prdata_d[7:0] = 8'(p7_latch_q);  // see R07 R09
      GP78_P8_DATA:  prdata_d[7:0] = data_view(8'(p8_latch_q),
                       8'(p8_dir_q), 8'h00, 8'(p8_lvl));
      GP78_P8_DIR:   prdata_d[7:0] = 8'(p8_dir_q);    // see R19 R22
      GP78_P8_PUL:   prdata_d[7:0] = 8'(p8_pul_q);
      GP78_P8_LATCH: prdata_d[7:0] = 8'(p8_latch_q);
      GP78_CFG:      prdata_d[7:0] = 8'(cfg_q);
      default:       prdata_d = '0;
    endcase
  end

  // Read data captured at setup, stable through the access phase
  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      PRDATA <= '0;
    end else if (setup && !PWRITE) begin
      PRDATA <= prdata_d;
    end
  end

  // Output latches are written whatever the direction
  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      p7_latch_q <= P7_WIDTH'(`GP78_RST_LATCH);
      p8_latch_q <= P8_WIDTH'(`GP78_RST_LATCH);
    end else if (wr_en) begin
      if (sel == GP78_P7_DATA || sel == GP78_P7_LATCH) begin
        p7_latch_q <= PWDATA[P7_WIDTH-1:0];           // see R03 R06
      end
      if (sel == GP78_P8_DATA || sel == GP78_P8_LATCH) begin
        p8_latch_q <= PWDATA[P8_WIDTH-1:0];           // see R03 R06
      end
    end
  end

  // Direction bits; reset leaves every pin an input
  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      p7_dir_q <= P7_WIDTH'(`GP78_RST_DIR);           // see R11
      p8_dir_q <= P8_WIDTH'(`GP78_RST_DIR);           // see R11
    end else if (wr_en) begin
      if (sel == GP78_P7_DIR) begin
        p7_dir_q <= PWDATA[P7_WIDTH-1:0];             // see R18 R22
      end
      if (sel == GP78_P8_DIR) begin
        p8_dir_q <= PWDATA[P8_WIDTH-1:0];             // see R19 R22
      end
    end
  end

  // Pull-up enables
  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      p7_pul_q <= P7_WIDTH'(`GP78_RST_PUL);
      p8_pul_q <= P8_WIDTH'(`GP78_RST_PUL);
    end else if (wr_en) begin
      if (sel == GP78_P7_PUL) begin
        p7_pul_q <= PWDATA[P7_WIDTH-1:0];             // see R16
      end
      if (sel == GP78_P8_PUL) begin
        p8_pul_q <= PWDATA[P8_WIDTH-1:0];             // see R16
      end
    end
  end

  // Float, trigger routing and interrupt enables
  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      cfg_q <= `GP78_RST_CFG;
    end else if (wr_en && sel == GP78_CFG) begin
      cfg_q <= PWDATA[`GP78_CFG_W-1:0];
    end
  end

  gp78_pin_cell #(
    .W (P7_WIDTH)
  ) u_p7 (
    .clk      (CLK_SYS),
    .rst      (SYS_RST),
    .latch    (p7_latch_q),
    .dir      (p7_dir_q),
    .pul      (p7_pul_q),
    .per_oe   (p7_per_oe),
    .per_out  (p7_per_out),
    .float_en (float_w),
    .keep_in  ({P7_WIDTH{1'b0}}),
    .pin_in   (P7_IN),
    .pin_out  (P7_OUT),
    .pin_oe   (P7_OE),
    .pin_pu   (P7_PULLUP),
    .pin_lvl  (p7_lvl)
  );

  gp78_pin_cell #(
    .W (P8_WIDTH)
  ) u_p8 (
    .clk      (CLK_SYS),
    .rst      (SYS_RST),
    .latch    (p8_latch_q),
    .dir      (p8_dir_q),
    .pul      (p8_pul_q),
    .per_oe   ({P8_WIDTH{1'b0}}),
    .per_out  ({P8_WIDTH{1'b0}}),
    .float_en (float_w),
    .keep_in  (p8_keep),
    .pin_in   (P8_IN),
    .pin_out  (P8_OUT),
    .pin_oe   (P8_OE),
    .pin_pu   (P8_PULLUP),
    .pin_lvl  (p8_lvl)
  );

  // Trigger source; a floated port 1 is the outside's concern
  assign trig_d = cfg_q[`GP78_CFG_TRIG_SEL] ? p8_lvl[`GP78_P8_TRIG]
                                           : P1_TRIG_IN; // see R20

  // Peripheral inputs registered so every output leaves a flop
  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      PPG_TRIG <= 1'b0;
      ADC_TRIG <= 1'b0;
      TMR0_IN  <= 1'b0;
    end else begin
      PPG_TRIG <= trig_d;                             // see R20
      ADC_TRIG <= trig_d;
      TMR0_IN  <= p7_lvl[`GP78_P7_TMR_IN];            // see R10
    end
  end

  // Checks
  sequence s_p7_out_set;
    wr_en && (sel == GP78_P7_DATA) && (&p7_dir_q) && !float_w &&
    !TMR0_OUT_EN;
  endsequence

  sequence s_p7_out_hold;
    (&p7_dir_q) && !float_w && !TMR0_OUT_EN;
  endsequence

  sequence s_p7_read;
    setup && !PWRITE && (sel == GP78_P7_DATA);
  endsequence

  latch_drive_a: assert property ( // see R02 R03
    @(posedge CLK_SYS) disable iff (SYS_RST)
    s_p7_out_set ##1 s_p7_out_hold |=>
      P7_OUT == $past(PWDATA[P7_WIDTH-1:0], 2))
    else $error("port 7 output does not follow latch write");

  no_drive_a: assert property ( // see R01 R05 R06
    @(posedge CLK_SYS) disable iff (SYS_RST)
    ##1 ((P7_OE & ~$past(p7_dir_q | p7_per_oe)) == '0) &&
        ((P8_OE & ~$past(p8_dir_q)) == '0))
    else $error("pin driven while an input");

  out_read_a: assert property ( // see R04 R09
    @(posedge CLK_SYS) disable iff (SYS_RST)
    s_p7_read |=> (PRDATA[P7_WIDTH-1:0] & $past(p7_dir_q & ~p7_per_oe)) ==
                  $past(p7_latch_q & p7_dir_q & ~p7_per_oe))
    else $error("output pin read not the latch");

  in_read_a: assert property ( // see R07 R10
    @(posedge CLK_SYS) disable iff (SYS_RST)
    s_p7_read |=> (PRDATA[P7_WIDTH-1:0] & ~$past(p7_dir_q)) ==
                  $past(p7_lvl & ~p7_dir_q))
    else $error("input pin read not the pin level");

  rmw_read_a: assert property ( // see R07
    @(posedge CLK_SYS) disable iff (SYS_RST)
    setup && !PWRITE && (sel == GP78_P8_LATCH) |=>
      PRDATA == 32'($past(p8_latch_q)) && PREADY)
    else $error("latch view read wrong");

  reset_dir_a: assert property ( // see R11
    @(posedge CLK_SYS) disable iff (SYS_RST)
    $past(SYS_RST) |-> (p7_dir_q == '0) && (p8_dir_q == '0) &&
                       (P7_OE == '0) && (P8_OE == '0))
    else $error("direction not cleared by reset");

  float_hiz_a: assert property ( // see R12
    @(posedge CLK_SYS) disable iff (SYS_RST)
    float_w |=> (P7_OE == '0) && (P8_OE == '0))
    else $error("pin driven in floated standby");

  float_low_a: assert property ( // see R13 R14
    @(posedge CLK_SYS) disable iff (SYS_RST)
    float_w && !p8_keep[`GP78_P8_TRIG] |=>
      (p7_lvl == '0) && (p8_lvl == '0))
    else $error("blocked input not read low");

  pullup_cut_a: assert property ( // see R17
    @(posedge CLK_SYS) disable iff (SYS_RST)
    ((P7_PULLUP & P7_OE & ~P7_OUT) == '0) &&
    ((P8_PULLUP & P8_OE & ~P8_OUT) == '0))
    else $error("pull-up on while driving low");

  trig_route_a: assert property ( // see R20
    @(posedge CLK_SYS) disable iff (SYS_RST)
    cfg_q[`GP78_CFG_TRIG_SEL] && $stable(cfg_q) |=>
      PPG_TRIG == $past(p8_lvl[`GP78_P8_TRIG]) && ADC_TRIG == PPG_TRIG)
    else $error("trigger not routed from port 8");

  upper_zero_a: assert property ( // see R22
    @(posedge CLK_SYS) disable iff (SYS_RST)
    PREADY |-> PRDATA[31:8] == 24'h000000)
    else $error("unimplemented bits read nonzero");

endmodule

// File: design/gp78_defs.svh
// Register offsets, field positions and reset values of the port 7/8 block.
// Assumes a byte-addressed APB slave with one 32-bit word per register.
`ifndef GP78_DEFS_SVH
`define GP78_DEFS_SVH

// Byte offsets on APB
`define GP78_OFS_P7_DATA   8'h00
`define GP78_OFS_P7_DIR    8'h04
`define GP78_OFS_P7_PUL    8'h08
`define GP78_OFS_P7_LATCH  8'h0C
`define GP78_OFS_P8_DATA   8'h10
`define GP78_OFS_P8_DIR    8'h14
`define GP78_OFS_P8_PUL    8'h18
`define GP78_OFS_P8_LATCH  8'h1C
`define GP78_OFS_CFG       8'h20

// Configuration register fields
`define GP78_CFG_W         4
`define GP78_CFG_FLOAT     0
`define GP78_CFG_TRIG_SEL  1
`define GP78_CFG_IRQ_CH0   2
`define GP78_CFG_IRQ_PSEL  3

// Shared pin positions
`define GP78_P7_TMR_OUT    0
`define GP78_P7_TMR_IN     1
`define GP78_P8_TRIG       3

// Reset values
`define GP78_RST_DIR       8'h00
`define GP78_RST_LATCH     8'h00
`define GP78_RST_PUL       8'h00
`define GP78_RST_CFG       4'h0

`endif

// File: design/gp78_pkg.sv
// Types shared by the port 7/8 block.
// Assumes gp78_defs.svh supplies the numeric constants.
package gp78_pkg;

  // Register selected by an APB address
  typedef enum logic [3:0] {
    GP78_REG_NONE  = 4'h0,
    GP78_P7_DATA   = 4'h1,
    GP78_P7_DIR    = 4'h2,
    GP78_P7_PUL    = 4'h3,
    GP78_P7_LATCH  = 4'h4,
    GP78_P8_DATA   = 4'h5,
    GP78_P8_DIR    = 4'h6,
    GP78_P8_PUL    = 4'h7,
    GP78_P8_LATCH  = 4'h8,
    GP78_CFG       = 4'h9
  } gp78_reg_t;

endpackage

// File: design/gp78_pin_cell.sv
// Pin cell for one port: drive, pull-up and gated input of W pins.
// Assumes pin inputs are synchronous to clk; all outputs are registered.
`timescale 1ns/1ns
module gp78_pin_cell #(
  parameter int W = 3
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] latch,
  input  wire logic [W-1:0] dir,
  input  wire logic [W-1:0] pul,
  input  wire logic [W-1:0] per_oe,
  input  wire logic [W-1:0] per_out,
  input  wire logic         float_en,
  input  wire logic [W-1:0] keep_in,
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] pin_out,
  output logic      [W-1:0] pin_oe,
  output logic      [W-1:0] pin_pu,
  output logic      [W-1:0] pin_lvl
);

  logic [W-1:0] drive;
  logic [W-1:0] value;
  logic [W-1:0] block;

  // Peripheral output overrides the latch; float overrides both
  assign drive = (dir | per_oe) & ~{W{float_en}};      // see R01 R05 R08 R12
  assign value = (per_oe & per_out) | (~per_oe & latch); // see R02 R08
  assign block = {W{float_en}} & ~keep_in;            // see R13 R14

  // Output stage; without float the levels simply hold
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_oe  <= '0;
      pin_out <= '0;
    end else begin
      pin_oe  <= drive;                               // see R06 R15
      pin_out <= value;                               // see R03
    end
  end

  // Pull-up cut while the pin drives low
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_pu <= '0;
    end else begin
      pin_pu <= pul & ~(drive & ~value);              // see R16 R17
    end
  end

  // Blocked inputs read low to avoid leakage from open pins
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_lvl <= '0;
    end else begin
      pin_lvl <= pin_in & ~block;                     // see R13
    end
  end

endmodule

// File: tb/gp78_pin_model.sv
// Outside world of one port: resolves each pin level from all drivers.
// Assumes the block's pin outputs are registered on clk.
`timescale 1ns/1ns
module gp78_pin_model #(
  parameter int W = 3
) (
  input  wire logic         clk,
  input  wire logic [W-1:0] oe,
  input  wire logic [W-1:0] out,
  input  wire logic [W-1:0] pu,
  input  wire logic [W-1:0] ext_en,
  input  wire logic [W-1:0] ext_val,
  output logic      [W-1:0] lvl
);
  logic [W-1:0] noise_q = '0;

  // Open pin wanders so a stale level never passes for a read
  always @(posedge clk) begin
    noise_q <= ~noise_q;
  end

  // Block drive wins, then outside driver, then pull-up
  always_comb begin
    for (int i = 0; i < W; i++) begin
      if (oe[i]) lvl[i] = out[i];
      else if (ext_en[i]) lvl[i] = ext_val[i];
      else if (pu[i]) lvl[i] = 1'b1;
      else lvl[i] = noise_q[i];
    end
  end
endmodule

// File: tb/tb_top.sv
// Self-checking bench for the port 7/8 block: APB master and pin models.
// Assumes the design package and constants header are compiled first.
`timescale 1ns/1ns
`include "gp78_defs.svh"
module tb_top;
  typedef struct {
    logic [7:0]  a;
    logic [31:0] wd;
    logic [31:0] ex;
  } gp78_row_t;

  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'hF;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, serr;
  logic        stby = 1'b0;
  logic [2:0]  p7_in, p7_out, p7_oe, p7_pu;
  logic [2:0]  p7_en = 3'h0, p7_val = 3'h0;
  logic [3:0]  p8_in, p8_out, p8_oe, p8_pu;
  logic [3:0]  p8_en = 4'h0, p8_val = 4'h0;
  logic        tmr_o = 1'b0, tmr_en = 1'b0, tmr_i;
  logic        p1_trig = 1'b0, ppg_trig, adc_trig;
  int          error_cnt = 0;
  int          checks = 0;
  gp78_row_t   rows[6] = '{
    '{`GP78_OFS_P7_DIR, 32'hFFFF_FFFF, 32'h7},
    '{`GP78_OFS_P8_DIR, 32'hFFFF_FFFF, 32'hF},
    '{`GP78_OFS_P7_PUL, 32'hFFFF_FFF5, 32'h5},
    '{`GP78_OFS_P8_PUL, 32'h0000_00FA, 32'hA},
    '{`GP78_OFS_P7_LATCH, 32'h0000_00FE, 32'h6},
    '{`GP78_OFS_P8_LATCH, 32'h0000_00F9, 32'h9}};

  // 20 MHz system clock
  always #25 clk = ~clk;

  gp78_ports dut (
    .CLK_SYS(clk), .SYS_RST(rst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .STANDBY_MODE(stby), .P7_IN(p7_in), .P7_OUT(p7_out), .P7_OE(p7_oe),
    .P7_PULLUP(p7_pu), .P8_IN(p8_in), .P8_OUT(p8_out), .P8_OE(p8_oe),
    .P8_PULLUP(p8_pu), .TMR0_OUT(tmr_o), .TMR0_OUT_EN(tmr_en),
    .TMR0_IN(tmr_i), .P1_TRIG_IN(p1_trig), .PPG_TRIG(ppg_trig),
    .ADC_TRIG(adc_trig));

  gp78_pin_model #(.W(3)) pins7 (.clk(clk), .oe(p7_oe), .out(p7_out),
    .pu(p7_pu), .ext_en(p7_en), .ext_val(p7_val), .lvl(p7_in));
  gp78_pin_model #(.W(4)) pins8 (.clk(clk), .oe(p8_oe), .out(p8_out),
    .pu(p8_pu), .ext_en(p8_en), .ext_val(p8_val), .lvl(p8_in));

  // Counts, verdict and end of run
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] ex,
                     input string what);
    checks++;
    if (got !== ex) begin
      error_cnt++;
      $display("FAIL %0t %s got %h want %h", $time, what, got, ex);
    end
  endtask

  // One APB transfer; an idle edge first keeps drivers from clashing
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      chk(32'h0, 32'h1, "no ready");
      give_verdict();
    end
    rd = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] ex,
                       input string what);
    apb(1'b0, a, 32'h0);
    chk(rd, ex, what);
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask

  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    // Reset state: all pins inputs
    rdchk(`GP78_OFS_P7_DIR, 32'h0, "p7 dir reset");
    rdchk(`GP78_OFS_P8_DIR, 32'h0, "p8 dir reset");
    chk(32'({p8_oe, p7_oe}), 32'h0, "oe after reset");
    // Register rows: write, read back, upper bits dropped
    foreach (rows[i]) begin
      apb(1'b1, rows[i].a, rows[i].wd);
      rdchk(rows[i].a, rows[i].ex, "row readback");
    end
    // Outputs drive latch; pull-up dropped where driving low
    p7_en <= 3'h7;
    p7_val <= 3'h1;
    wt(3);
    chk(32'({p8_oe, p8_out}), 32'hF9, "p8 drive");
    chk(32'({p8_pu, p7_pu}), 32'h44, "pull-ups");
    rdchk(`GP78_OFS_P7_DATA, 32'h6, "output read");
    apb(1'b1, `GP78_OFS_P7_DATA, 32'h3);
    wt(2);
    chk(32'(p7_out), 32'h3, "direct drive");
    // Input: latch written but not driven; reads split
    apb(1'b1, `GP78_OFS_P7_DIR, 32'h0);
    apb(1'b1, `GP78_OFS_P7_DATA, 32'h5);
    p7_val <= 3'h2;
    wt(3);
    chk(32'(p7_oe), 32'h0, "input oe");
    rdchk(`GP78_OFS_P7_DATA, 32'h2, "pin read");
    rdchk(`GP78_OFS_P7_LATCH, 32'h5, "latch read");
    chk(32'(tmr_i), 32'h1, "timer input");
    // Peripheral output replaces latch on port 7 bit 0
    p7_en <= 3'h6;
    apb(1'b1, `GP78_OFS_P7_LATCH, 32'h4);
    apb(1'b1, `GP78_OFS_P7_DIR, 32'h1);
    tmr_o <= 1'b1;
    tmr_en <= 1'b1;
    wt(3);
    chk(32'({p7_oe[0], p7_out[0]}), 32'h3, "periph drive");
    rdchk(`GP78_OFS_P7_DATA, 32'h3, "periph read");
    rdchk(`GP78_OFS_P7_LATCH, 32'h4, "periph rmw");
    // Peripheral off before port use
    tmr_en <= 1'b0;
    wt(2);
    chk(32'(p7_out[0]), 32'h0, "latch back");
    // Pull-ups hold undriven input pins high
    apb(1'b1, `GP78_OFS_P8_DIR, 32'h0);
    p8_en <= 4'h5;
    wt(3);
    chk(32'(p8_pu), 32'hA, "pull-up input");
    rdchk(`GP78_OFS_P8_DATA, 32'hA, "pulled read");
    // Standby float: pins released, inputs read low
    apb(1'b1, `GP78_OFS_P8_DIR, 32'h7);
    apb(1'b1, `GP78_OFS_CFG, 32'h1);
    stby <= 1'b1;
    wt(2);
    chk(32'({p8_oe, p7_oe}), 32'h0, "float oe");
    p8_en <= 4'hF;
    p8_val <= 4'hF;
    wt(3);
    // Output bits still read the latch; the input bit is blocked
    rdchk(`GP78_OFS_P8_DATA, 32'h1, "float blocked");
    rdchk(`GP78_OFS_P7_DATA, 32'h0, "float p7 blocked");
    chk(32'(tmr_i), 32'h0, "timer in blocked");
    apb(1'b1, `GP78_OFS_CFG, 32'hD);
    wt(3);
    rdchk(`GP78_OFS_P8_DATA, 32'h9, "irq pin live");
    p8_en <= 4'h0;
    apb(1'b1, `GP78_OFS_CFG, 32'h0);
    wt(2);
    chk(32'({p8_oe, p8_out}), 32'h79, "standby hold");
    stby <= 1'b0;
    // Trigger routing: port 8 bit 3 or port 1
    apb(1'b1, `GP78_OFS_P8_DIR, 32'h0);
    apb(1'b1, `GP78_OFS_CFG, 32'h2);
    p8_en <= 4'hF;
    p8_val <= 4'h8;
    wt(3);
    chk(32'({ppg_trig, adc_trig}), 32'h3, "trig p8");
    // Sources swap levels so a stuck select shows up
    p1_trig <= 1'b1;
    p8_val <= 4'h0;
    apb(1'b1, `GP78_OFS_CFG, 32'h0);
    wt(3);
    chk(32'({ppg_trig, adc_trig}), 32'h3, "trig p1");
    // Refusals: unmapped address, lane 0 strobe off
    apb(1'b0, 8'h24, 32'h0);
    chk(32'(serr), 32'h1, "unmapped error");
    chk(rd, 32'h0, "unmapped data");
    pstrb <= 4'h0;
    apb(1'b1, `GP78_OFS_P7_PUL, 32'h2);
    pstrb <= 4'hF;
    rdchk(`GP78_OFS_P7_PUL, 32'h5, "strobe off");
    // Second reset in mid-run
    rst <= 1'b1;
    wt(2);
    rst <= 1'b0;
    rdchk(`GP78_OFS_P8_DIR, 32'h0, "mid reset");
    give_verdict();
  end
endmodule
